// ### inc/supervisor_pkg.sv
// package: constants for the supply supervisor with watchdog and reset stretch
// Operation
// - active-low reset output is open-drain, pulls only
// - active-high push-pull reset is inverse of active-low
// - undervoltage asserts both; margin input picks 10%/5%
// - hold resets 250ms after undervoltage clears, incl. power-up
// - resets stay asserted while supply stays low
// - debounced manual low asserts both resets
// - hold resets 250ms after the debounced release, which comes 19ms after manual input returns high
// - manual low pulses over 20ms always recognised
// - timeout select: ground 150ms, open 610ms, supply 1200ms
// - no strobe falling edge before timeout asserts resets
// - strobe pulses of 20ns are detected
// - strobe ignored while reset is asserted
// - watchdog cannot be disabled; only falling edge restarts
package supervisor_pkg;
    // clock and time base
    localparam int unsigned CLOCK_HZ = 100_000_000;
    localparam int unsigned TICK_US = 1000;
    localparam int unsigned TICK_CYCLES = CLOCK_HZ / 1_000_000 * TICK_US;
    localparam int TICK_W = 17;
    // interval counts in 1 ms ticks
    localparam int CNT_W = 11;
    localparam int unsigned STRETCH_MS = 250;
    localparam logic [CNT_W-1:0] STRETCH_TICKS = CNT_W'(STRETCH_MS + 1);
    localparam int unsigned PB_MIN_LOW_MS = 20;
    localparam logic [CNT_W-1:0] PB_TICKS = CNT_W'(PB_MIN_LOW_MS - 1);
    localparam int unsigned WD_GND_MS = 150;
    localparam int unsigned WD_OPEN_MS = 610;
    localparam int unsigned WD_VCC_MS = 1200;
    localparam logic [CNT_W-1:0] WD_GND_TICKS = CNT_W'(WD_GND_MS);
    localparam logic [CNT_W-1:0] WD_OPEN_TICKS = CNT_W'(WD_OPEN_MS);
    localparam logic [CNT_W-1:0] WD_VCC_TICKS = CNT_W'(WD_VCC_MS);
    // three-level timeout select coding
    localparam logic [1:0] TD_GND = 2'h0;
    localparam logic [1:0] TD_OPEN = 2'h1;
    localparam logic [1:0] TD_VCC = 2'h2;
    // register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] WDCOUNT_OFS = 8'h08;
    // control fields
    localparam int CTRL_SOFT_RESET_BIT = 0;
    // status fields
    localparam int ST_RESET_ACTIVE_BIT = 0;
    localparam int ST_SUPPLY_LOW_BIT = 1;
    localparam int ST_PB_PRESSED_BIT = 2;
    localparam int ST_MARGIN_BIT = 3;
    localparam int ST_PIN_LEVEL_BIT = 4;
    localparam int ST_TD_LSB = 8;
    localparam int ST_STATE_LSB = 12;
    // reset values
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
    localparam logic [CNT_W-1:0] CNT_RESET = 11'h000;
    // supervisor states, one-hot
    typedef enum logic [2:0] {
        SV_HOLD = 3'h1,
        SV_STRETCH = 3'h2,
        SV_RUN = 3'h4
    } sv_state_e;
endpackage : supervisor_pkg

// ### design/pushbutton_debounce.sv
// module: tick-based debouncer for the manual reset input
`timescale 1ns/100ps
`default_nettype none
module pushbutton_debounce (
    input wire logic clock,
    input wire logic resetn,
    input wire logic tick,
    input wire logic button_n,
    output logic pressed
);
    logic [supervisor_pkg::CNT_W-1:0] low_cnt_reg;
    logic [supervisor_pkg::CNT_W-1:0] high_cnt_reg;
    logic pressed_reg;
    wire low_done = (low_cnt_reg >= supervisor_pkg::PB_TICKS);
    wire high_done = (high_cnt_reg >= supervisor_pkg::PB_TICKS);

    // widen a one-bit increment to the counter width
    function automatic logic [supervisor_pkg::CNT_W-1:0] cnt_inc(input logic inc);
        cnt_inc = {{(supervisor_pkg::CNT_W-1){1'b0}}, inc};
    endfunction : cnt_inc

    // any opposite sample restarts a run, so contact bounce never counts
    always_ff @(posedge clock) begin
        if (!resetn) begin
            low_cnt_reg <= supervisor_pkg::CNT_RESET;
            high_cnt_reg <= supervisor_pkg::CNT_RESET;
        end else begin
            low_cnt_reg <= button_n ? supervisor_pkg::CNT_RESET : low_cnt_reg + cnt_inc(tick && !low_done);
            high_cnt_reg <= !button_n ? supervisor_pkg::CNT_RESET : high_cnt_reg + cnt_inc(tick && !high_done);
        end
    end

    // press after a long low run, release after a long high run
    always_ff @(posedge clock) begin
        if (!resetn) begin
            pressed_reg <= 1'b0;
        end else if (!button_n && low_done) begin
            pressed_reg <= 1'b1;
        end else if (button_n && high_done) begin
            pressed_reg <= 1'b0;
        end
    end

    assign pressed = pressed_reg;

    a_debounce_press: assert property (@(posedge clock) disable iff (!resetn)
        (!button_n && low_done) |=> pressed_reg)
        else $error("debounced low run did not register a press");
endmodule : pushbutton_debounce
`default_nettype wire

// ### design/supply_supervisor_watchdog_reset.sv
// module: supply supervisor, push-button and watchdog reset generator with AHB-Lite status
`timescale 1ns/100ps
`default_nettype none
module supply_supervisor_watchdog_reset #(
    parameter int unsigned TICK_CYCLES = supervisor_pkg::TICK_CYCLES
) (
    input wire logic clock,
    input wire logic resetn,
    // supply comparator, straps, manual input and watchdog strobe
    input wire logic supply_low,
    input wire logic trip_margin_select,
    input wire logic [1:0] timeout_select,
    input wire logic manual_reset_n,
    input wire logic watchdog_kick_n,
    // reset pins and margin output
    input wire logic reset_n_in,
    output logic reset_n_out,
    output logic reset_n_oe,
    output logic reset_out,
    output logic margin_10pct,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp
);
    localparam int CW = supervisor_pkg::CNT_W;
    localparam int TW = supervisor_pkg::TICK_W;

    // widen a one-bit increment to the counter width
    function automatic logic [CW-1:0] inc_of(input logic bit_in);
        inc_of = {{(CW-1){1'b0}}, bit_in};
    endfunction : inc_of

    // timeout in ticks for a three-level select code
    function automatic logic [CW-1:0] wd_limit_of(input logic [1:0] sel);
        logic [CW-1:0] lim;
        // code 3 has no strap meaning; it falls back to the longest timeout
        lim = supervisor_pkg::WD_VCC_TICKS;
        if (sel == supervisor_pkg::TD_GND) begin
            lim = supervisor_pkg::WD_GND_TICKS;
        end else if (sel == supervisor_pkg::TD_OPEN) begin
            lim = supervisor_pkg::WD_OPEN_TICKS;
        end
        wd_limit_of = lim;
    endfunction : wd_limit_of

    logic [supervisor_pkg::TICK_W-1:0] div_reg;
    logic tick_reg;
    logic kick_prev_reg;
    logic soft_req_reg;
    // interval counters, all in ms ticks
    logic [CW-1:0] stretch_cnt_reg;
    logic [CW-1:0] wd_cnt_reg;
    logic reset_active_reg;
    logic margin_reg;
    // bus-side registers
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic [31:0] hrdata_reg;
    logic hreadyout_reg;
    logic pb_pressed;
    supervisor_pkg::sv_state_e state_reg;
    supervisor_pkg::sv_state_e state_next;

    // free-running 1 ms time base shared by every interval counter
    wire div_wrap = (div_reg == TW'(TICK_CYCLES - 1));

    always_ff @(posedge clock) begin
        if (!resetn) begin
            div_reg <= '0;
            tick_reg <= 1'b0;
        end else begin
            div_reg <= div_wrap ? '0 : div_reg + 1'b1;
            tick_reg <= div_wrap;
        end
    end

    // manual input debouncing lives in its own module
    pushbutton_debounce u_debounce (
        .clock(clock),
        .resetn(resetn),
        .tick(tick_reg),
        .button_n(manual_reset_n),
        .pressed(pb_pressed)
    );

    // strobe edge: two samples suffice since a 20 ns pulse spans two clocks
    wire kick_fall = kick_prev_reg && !watchdog_kick_n;
    wire in_run = (state_reg == supervisor_pkg::SV_RUN);
    wire kick_taken = in_run && kick_fall;
    wire [CW-1:0] wd_limit = wd_limit_of(timeout_select);
    wire wd_expire = in_run && (wd_cnt_reg >= wd_limit);
    wire hold_cause = supply_low || pb_pressed;
    wire pulse_cause = wd_expire || soft_req_reg;
    wire stretch_done = (stretch_cnt_reg >= supervisor_pkg::STRETCH_TICKS);

    always_ff @(posedge clock) begin
        if (!resetn) begin
            kick_prev_reg <= 1'b1;
        end else begin
            kick_prev_reg <= watchdog_kick_n;
        end
    end

    // level causes hold, one-shot causes restart the stretch
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            supervisor_pkg::SV_HOLD: begin
                if (!hold_cause) begin
                    state_next = supervisor_pkg::SV_STRETCH;
                end
            end
            supervisor_pkg::SV_STRETCH: begin
                if (hold_cause) begin
                    state_next = supervisor_pkg::SV_HOLD;
                end else if (stretch_done && !pulse_cause) begin
                    state_next = supervisor_pkg::SV_RUN;
                end
            end
            supervisor_pkg::SV_RUN: begin
                if (hold_cause) begin
                    state_next = supervisor_pkg::SV_HOLD;
                end else if (pulse_cause) begin
                    state_next = supervisor_pkg::SV_STRETCH;
                end
            end
            default: begin
                state_next = supervisor_pkg::SV_HOLD;
            end
        endcase
    end

    // power-up starts in hold so the stretch also covers power-on
    always_ff @(posedge clock) begin
        if (!resetn) begin
            state_reg <= supervisor_pkg::SV_HOLD;
        end else begin
            state_reg <= state_next;
        end
    end

    // stretch count restarts on every new cause, so at least 250 full ticks pass
    wire stretch_keep = (state_reg == supervisor_pkg::SV_STRETCH) && !pulse_cause && !stretch_done;

    always_ff @(posedge clock) begin
        if (!resetn) begin
            stretch_cnt_reg <= supervisor_pkg::CNT_RESET;
        end else if (state_reg != supervisor_pkg::SV_STRETCH || pulse_cause) begin
            stretch_cnt_reg <= supervisor_pkg::CNT_RESET;
        end else begin
            stretch_cnt_reg <= stretch_cnt_reg + inc_of(stretch_keep && tick_reg);
        end
    end

    // watchdog has no enable: it always runs outside reset
    always_ff @(posedge clock) begin
        if (!resetn) begin
            wd_cnt_reg <= supervisor_pkg::CNT_RESET;
        end else if (!in_run || kick_taken) begin
            wd_cnt_reg <= supervisor_pkg::CNT_RESET;
        end else if (!wd_expire) begin
            wd_cnt_reg <= wd_cnt_reg + inc_of(tick_reg);
        end
    end

    // pins: open-drain low side and push-pull inverse share one flop source
    always_ff @(posedge clock) begin
        if (!resetn) begin
            reset_active_reg <= 1'b1;
            margin_reg <= 1'b0;
        end else begin
            reset_active_reg <= (state_next != supervisor_pkg::SV_RUN);
            margin_reg <= trip_margin_select;
        end
    end

    assign reset_n_out = 1'b0;
    assign reset_n_oe = reset_active_reg;
    assign reset_out = reset_active_reg;
    assign margin_10pct = margin_reg;

    // AHB-Lite: zero wait states, always OKAY
    // map: word 0 control, word 1 status, word 2 watchdog count
    // control bit 0 written high restarts the stretch like an expiry would
    // status keeps pin, cause and state bits apart so software can tell why
    // anything outside the three words reads zero and ignores writes
    // byte and halfword accesses are refused the same way, since fields span bytes
    wire addr_phase = hsel && htrans[1] && hready;
    wire [7:0] addr_lo = haddr[7:0];
    wire addr_ctrl = (addr_lo == supervisor_pkg::CTRL_OFS);
    wire addr_status = (addr_lo == supervisor_pkg::STATUS_OFS);
    wire addr_wdcount = (addr_lo == supervisor_pkg::WDCOUNT_OFS);
    wire upper_zero = (haddr[31:8] == 24'h000000) && (hsize == 3'h2);
    wire [31:0] status_word = {16'h0000, 1'b0, state_reg, 1'b0, 1'b0, timeout_select,
        3'h0, reset_n_in, margin_reg, pb_pressed, supply_low, reset_active_reg};
    wire [31:0] rd_mux = !upper_zero ? 32'h0000_0000 :
        addr_ctrl ? {31'h0000_0000, soft_req_reg} :
        addr_status ? status_word :
        addr_wdcount ? {21'h00_0000, wd_cnt_reg} : 32'h0000_0000;
    wire wr_ctrl_hit = wr_pend_reg && (wr_addr_reg == supervisor_pkg::CTRL_OFS);

    // read data captured at the address phase so it stands in the data phase
    always_ff @(posedge clock) begin
        if (!resetn) begin
            hrdata_reg <= supervisor_pkg::RDATA_RESET;
            hreadyout_reg <= 1'b0;
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            hreadyout_reg <= 1'b1;
            wr_pend_reg <= addr_phase && hwrite && upper_zero;
            wr_addr_reg <= addr_lo;
            if (addr_phase && !hwrite) begin
                hrdata_reg <= rd_mux;
            end
        end
    end

    // software reset request is a one-cycle pulse into the stretch path
    always_ff @(posedge clock) begin
        if (!resetn) begin
            soft_req_reg <= 1'b0;
        end else begin
            soft_req_reg <= wr_ctrl_hit && hwdata[supervisor_pkg::CTRL_SOFT_RESET_BIT];
        end
    end

    assign hrdata = hrdata_reg;
    assign hreadyout = hreadyout_reg;
    assign hresp = 1'b0;

    // helper sequences for checks
    sequence s_run_kick;
        in_run && kick_fall && !hold_cause && !pulse_cause;
    endsequence

    sequence s_run_tick;
        in_run && tick_reg && !kick_fall && !wd_expire && !hold_cause && !soft_req_reg;
    endsequence

    // both pin views come from the one reset flop
    a_reset_complement: assert property (@(posedge clock) disable iff (!resetn)
        reset_out == reset_n_oe && reset_n_out == 1'b0)
        else $error("reset outputs are not complementary");

    // a one-cycle dip still lands in hold, and the stretch keeps reset up after it
    a_undervolt_reset: assert property (@(posedge clock) disable iff (!resetn)
        supply_low |=> (reset_out && state_reg == supervisor_pkg::SV_HOLD) ##1 reset_out)
        else $error("undervoltage did not assert reset");

    // a supply that stays low never lets reset go
    a_hold_during_low: assert property (@(posedge clock) disable iff (!resetn)
        supply_low [*2] |-> reset_out)
        else $error("reset released while supply low");

    // release only after the full stretch count
    a_stretch_length: assert property (@(posedge clock) disable iff (!resetn)
        $rose(in_run) |-> $past(stretch_cnt_reg) == supervisor_pkg::STRETCH_TICKS)
        else $error("reset released before stretch completed");

    // a debounced press leaves run and raises reset
    a_pb_reset: assert property (@(posedge clock) disable iff (!resetn)
        pb_pressed |=> !in_run ##1 reset_out)
        else $error("manual reset did not assert reset");

    // an accepted strobe edge clears the count but keeps run
    a_kick_restart: assert property (@(posedge clock) disable iff (!resetn)
        s_run_kick |=> wd_cnt_reg == supervisor_pkg::CNT_RESET && in_run)
        else $error("accepted strobe did not restart watchdog");

    // each tick in run with no strobe edge advances the count by exactly one, until expiry holds it
    a_wd_counts: assert property (@(posedge clock) disable iff (!resetn)
        s_run_tick |=> wd_cnt_reg == $past(wd_cnt_reg) + 11'h001)
        else $error("watchdog did not advance on tick");

    // reaching the limit ends run on the next edge
    a_wd_timeout: assert property (@(posedge clock) disable iff (!resetn)
        (in_run && wd_cnt_reg == wd_limit && !hold_cause) |=>
        state_reg == supervisor_pkg::SV_STRETCH ##0 reset_out)
        else $error("watchdog expiry did not assert reset");

    // outside run the count is pinned at zero, so strobes do nothing
    a_kick_ignored: assert property (@(posedge clock) disable iff (!resetn)
        (!in_run) |=> wd_cnt_reg == supervisor_pkg::CNT_RESET)
        else $error("strobe or count acted during reset");

    // margin strap reaches the comparator one edge later
    a_margin_follow: assert property (@(posedge clock) disable iff (!resetn)
        1'b1 |=> margin_10pct == $past(trip_margin_select))
        else $error("margin select not passed to comparator");

    // one step of the stretch: a tick while still counting and no new cause
    sequence s_stretch_tick;
        state_reg == supervisor_pkg::SV_STRETCH && tick_reg && !stretch_done && !pulse_cause;
    endsequence

    // the active-high pin tracks the state, so no output glitch outside run
    a_pin_state_match: assert property (@(posedge clock) disable iff (!resetn)
        reset_out == (state_reg != supervisor_pkg::SV_RUN))
        else $error("reset pin disagrees with supervisor state");

    // between ticks nothing but an accepted strobe edge may move the count
    a_count_frozen: assert property (@(posedge clock) disable iff (!resetn)
        (in_run && !tick_reg && !kick_fall) |=> $stable(wd_cnt_reg))
        else $error("watchdog count moved without tick or strobe");

    // an unfinished stretch never hands over to run
    a_stretch_no_early: assert property (@(posedge clock) disable iff (!resetn)
        (state_reg == supervisor_pkg::SV_STRETCH && !stretch_done) |=> !in_run)
        else $error("reset released before stretch count finished");

    // each stretch tick adds one, so the count measures whole ms
    a_stretch_counts: assert property (@(posedge clock) disable iff (!resetn)
        s_stretch_tick |=> stretch_cnt_reg == $past(stretch_cnt_reg) + 11'h001)
        else $error("stretch count did not advance on tick");

    // every tick lands on the divider wrap, so all intervals share one base
    a_tick_aligned: assert property (@(posedge clock) disable iff (!resetn)
        tick_reg |-> div_reg == '0)
        else $error("time base tick out of step with divider");

    // a software request restarts the stretch from zero
    a_soft_restart: assert property (@(posedge clock) disable iff (!resetn)
        (soft_req_reg && !hold_cause) |=> (state_reg == supervisor_pkg::SV_STRETCH && reset_out
        && stretch_cnt_reg == supervisor_pkg::CNT_RESET))
        else $error("software reset did not restart stretch");

    // a level cause always parks the machine in hold
    a_hold_on_cause: assert property (@(posedge clock) disable iff (!resetn)
        hold_cause |=> state_reg == supervisor_pkg::SV_HOLD)
        else $error("level cause did not hold the supervisor");

    // leaving reset starts the watchdog from zero
    a_release_restart: assert property (@(posedge clock) disable iff (!resetn)
        $rose(in_run) |-> wd_cnt_reg == supervisor_pkg::CNT_RESET)
        else $error("watchdog not restarted at reset release");
endmodule : supply_supervisor_watchdog_reset
`default_nettype wire

// ### bench/host_model.sv
// host model: strobes the watchdog, owns the button and pulls up the reset wire
`timescale 1ns/100ps
`default_nettype none
module host_model (
    input wire logic clock,
    input wire logic kick_enable,
    input wire logic [11:0] kick_period,
    input wire logic button_press,
    input wire logic reset_n_out,
    input wire logic reset_n_oe,
    output logic reset_n_in,
    output logic watchdog_kick_n,
    output logic manual_reset_n
);
    logic [11:0] kick_cnt_reg;
    // wire level: device pulls low, otherwise the external pull-up wins
    assign reset_n_in = reset_n_oe ? reset_n_out : 1'b1;
    // an untouched button reads high through its pull-up
    assign manual_reset_n = button_press ? 1'b0 : 1'b1;
    // period counter; held at zero while strobing is off
    always_ff @(posedge clock) begin
        if (!kick_enable || kick_cnt_reg == kick_period) begin
            kick_cnt_reg <= 12'h000;
        end else begin
            kick_cnt_reg <= kick_cnt_reg + 12'h001;
        end
    end
    // two-cycle (20 ns) low strobe, repeated well inside the shortest timeout
    assign watchdog_kick_n = !(kick_enable && kick_cnt_reg < 12'h002);
endmodule : host_model
`default_nettype wire

// ### bench/supply_supervisor_watchdog_reset_tb_top.sv
// testbench: supervisor reset causes, stretch, watchdog and status reads
`timescale 1ns/100ps
`default_nettype none
module supply_supervisor_watchdog_reset_tb_top;
    localparam int TC = 10;
    logic clock = 1'b0;
    logic resetn, supply_low, trip_margin_select, manual_reset_n, watchdog_kick_n;
    logic [1:0] timeout_select;
    logic reset_n_in, reset_n_out, reset_n_oe, reset_out, margin_10pct;
    logic hsel, hwrite, hreadyout, hresp, kick_enable, button_press;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    wire hready;
    int bad_count = 0;
    int compares = 0;
    int n;
    int lims [4] = '{150, 610, 1200, 1200};
    // one slave only, so its ready is the bus ready
    assign hready = hreadyout;
    always #5 clock = ~clock;
    supply_supervisor_watchdog_reset #(.TICK_CYCLES(TC)) i_dut (
        .clock(clock), .resetn(resetn), .supply_low(supply_low),
        .trip_margin_select(trip_margin_select), .timeout_select(timeout_select),
        .manual_reset_n(manual_reset_n), .watchdog_kick_n(watchdog_kick_n),
        .reset_n_in(reset_n_in), .reset_n_out(reset_n_out), .reset_n_oe(reset_n_oe),
        .reset_out(reset_out), .margin_10pct(margin_10pct), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp)
    );
    host_model i_host (
        .clock(clock), .kick_enable(kick_enable), .kick_period(12'h1F4),
        .button_press(button_press), .reset_n_out(reset_n_out), .reset_n_oe(reset_n_oe),
        .reset_n_in(reset_n_in), .watchdog_kick_n(watchdog_kick_n), .manual_reset_n(manual_reset_n)
    );
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task chk_rng(input string what, input int lo, input int hi, input logic [31:0] got);
        compares++;
        if ((^got === 1'bx) || got < lo || got > hi) begin
            bad_count++;
            $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask : chk_rng
    // three pin views of the reset must agree with level v; reset_n_out must read low for either level
    task pins(input logic v);
        chk("reset_out", {31'h0, v}, {31'h0, reset_out});
        chk("reset_n_oe", {31'h0, v}, {31'h0, reset_n_oe});
        chk("reset_n_in", {31'h0, ~v}, {31'h0, reset_n_in});
        chk("reset_n_out", 32'h0, {31'h0, reset_n_out});
    endtask : pins
    // counts edges until reset_out shows v; bounded so a hang shows as a range miss
    task wait_rst(input logic v, input int maxc, output int cnt);
        cnt = 0;
        while (reset_out !== v && cnt < maxc) begin
            @(posedge clock);
            cnt++;
        end
    endtask : wait_rst
    // single word transfer; entered just after a rising edge
    task ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rdat);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge clock); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clock); while (hready !== 1'b1);
        rdat = hrdata;
    endtask : ahb
    task results;
        $display("counts: %0d compares, %0d mismatches", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results
    // run is about 60k cycles; this limit leaves ample slack
    initial begin
        #1_000_000;
        bad_count++;
        results();
    end
    initial begin
        resetn = 1'b0;
        supply_low = 1'b0;
        trip_margin_select = 1'b0;
        timeout_select = 2'h0;
        kick_enable = 1'b0;
        button_press = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        wait_rst(1'b0, 300 * TC, n);
        chk_rng("power-up stretch", 250 * TC, 253 * TC, n);
        pins(1'b0);
        $display("test power-up done");
        kick_enable <= 1'b1;
        repeat (3000) @(posedge clock);
        pins(1'b0);
        ahb(1'b0, 32'h0000_0008, 32'h0, rd);
        chk_rng("kicked count", 0, 51, rd);
        chk("bus response", 32'h0, {31'h0, hresp});
        ahb(1'b0, 32'h0000_0004, 32'h0, rd);
        chk("run state", 32'h4, {29'h0, rd[14:12]});
        ahb(1'b0, 32'h0000_0040, 32'h0, rd);
        chk("unmapped read", 32'h0, rd);
        $display("test kicking done");
        for (int t = 0; t < 2; t++) begin
            trip_margin_select <= t[0];
            supply_low <= 1'b1;
            wait_rst(1'b1, 5, n);
            chk_rng("undervoltage assert", 0, 3, n);
            repeat (500) @(posedge clock);
            pins(1'b1);
            chk("margin", {31'h0, t[0]}, {31'h0, margin_10pct});
            ahb(1'b0, 32'h0000_0004, 32'h0, rd);
            chk("status low", {28'h0, t[0], 3'h3}, {28'h0, rd[3:0]});
            ahb(1'b0, 32'h0000_0008, 32'h0, rd);
            chk("count in reset", 32'h0, rd);
            supply_low <= 1'b0;
            wait_rst(1'b0, 300 * TC, n);
            chk_rng("undervoltage stretch", 250 * TC, 253 * TC, n);
        end
        $display("test undervoltage done");
        button_press <= 1'b1;
        wait_rst(1'b1, 25 * TC, n);
        chk_rng("button assert", 18 * TC, 21 * TC, n);
        repeat (25 * TC - n) @(posedge clock);
        button_press <= 1'b0;
        wait_rst(1'b0, 300 * TC, n);
        chk_rng("button stretch", 250 * TC, 272 * TC, n);
        $display("test button done");
        kick_enable <= 1'b0;
        // no strobes: each timeout measured from the release after a soft reset
        for (int i = 0; i < 4; i++) begin
            timeout_select <= i[1:0];
            ahb(1'b1, 32'h0000_0000, 32'h1, rd);
            wait_rst(1'b1, 5, n);
            wait_rst(1'b0, 300 * TC, n);
            chk_rng("soft stretch", 248 * TC, 253 * TC, n);
            wait_rst(1'b1, (lims[i] + 5) * TC, n);
            chk_rng("watchdog timeout", (lims[i] - 1) * TC, (lims[i] + 1) * TC, n);
        end
        $display("test watchdog done");
        results();
    end
endmodule : supply_supervisor_watchdog_reset_tb_top
`default_nettype wire
